// *** design/css_pkg.sv ***
// shared constants, types and register map for the command source selector
package css_pkg;

    // sizes
    localparam int NUM_FUNC = 75;
    localparam int NUM_TERM = 12;
    localparam int CODE_W   = 7;

    // input function codes with special handling
    localparam logic [6:0] FC_SWITCH = 7'h43;
    localparam logic [6:0] FC_SIGN   = 7'h44;
    localparam logic [6:0] FC_TUNE   = 7'h1c;
    localparam logic [6:0] FC_RESET  = 7'h3e;
    localparam logic [6:0] FC_NONE   = 7'h7f;

    // source parameter encodings
    localparam logic       OPSRC_NET   = 1'b0;
    localparam logic [1:0] SPDSRC_NET  = 2'h0;
    localparam logic [1:0] COMP_ON     = 2'h1;

    // register byte offsets (low address byte)
    localparam logic [7:0] A_OPSRC  = 8'h00;
    localparam logic [7:0] A_SPDSRC = 8'h04;
    localparam logic [7:0] A_COMP   = 8'h08;
    localparam logic [7:0] A_COMMA  = 8'h0c;
    localparam logic [7:0] A_COMMB  = 8'h10;
    localparam logic [7:0] A_MODE   = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_TERM   = 8'h40;

    // reset values
    localparam logic       OPSRC_RST  = 1'b0;
    localparam logic [1:0] SPDSRC_RST = 2'h0;
    localparam logic [1:0] COMP_RST   = 2'h0;
    localparam logic       COMM_RST   = 1'b0;
    localparam logic       MODE_RST   = 1'b0;
    localparam logic [6:0] TERM_RST   = 7'h7f;

    // status register bit positions
    localparam int ST_ASSIGNED = 0;
    localparam int ST_APPLIED  = 1;
    localparam int ST_PENDING  = 2;
    localparam int ST_OPNET    = 3;
    localparam int ST_SPDNET   = 4;
    localparam int ST_SWOK     = 5;

    // control class of one input function
    typedef enum logic [3:0] {
        CLS_EXT  = 4'b0001,
        CLS_NET  = 4'b0010,
        CLS_COMB = 4'b0100,
        CLS_NONE = 4'b1000
    } css_cls_type;

    // switching input tracking
    typedef enum logic [1:0] {
        SW_STABLE  = 2'b01,
        SW_PENDING = 2'b10
    } css_sw_type;

    // resolved command sources
    typedef struct packed {
        logic op_net;
        logic spd_net;
        logic op_port;
        logic spd_port;
    } css_sel_type;

endpackage : css_pkg

// *** design/css_func_class.sv ***
// per-function control class decoder
`timescale 1ns/100ps
module css_func_class (
    input  wire logic [6:0]          code,
    input  wire css_pkg::css_sel_type sel,
    output css_pkg::css_cls_type     cls,
    output logic                     spd_grp
);

    // class follows the operation or speed command source of the function; codes 04, 44, the terminal-only list and unlisted codes are fixed
    always_comb begin
        cls     = css_pkg::CLS_NONE;
        spd_grp = 1'b0;
        unique case (code)
            7'h00, 7'h01, 7'h02, 7'h08, 7'h0e, 7'h40: begin
                spd_grp = 1'b1;
                cls = sel.spd_net ? css_pkg::CLS_NET : css_pkg::CLS_EXT;
            end
            7'h03, 7'h09, 7'h0d, 7'h0f, 7'h11, 7'h12, 7'h13, 7'h14,
            7'h16, 7'h17, 7'h1a, 7'h1b, 7'h2a, 7'h2b, 7'h2c, 7'h32,
            7'h3c, 7'h3d, 7'h46, 7'h47, 7'h4a: begin
                cls = sel.op_net ? css_pkg::CLS_NET : css_pkg::CLS_EXT;
            end
            css_pkg::FC_TUNE: begin
                cls = sel.op_net ? css_pkg::CLS_NET : css_pkg::CLS_EXT;
            end
            7'h04: begin
                cls = css_pkg::CLS_COMB;
            end
            7'h18: begin
                cls = sel.op_net ? css_pkg::CLS_COMB : css_pkg::CLS_EXT;
            end
            7'h05, 7'h19: begin
                // no source at all while operation commands come from the network
                cls = sel.op_net ? css_pkg::CLS_NONE : css_pkg::CLS_EXT;
            end
            css_pkg::FC_SIGN: begin
                cls = css_pkg::CLS_EXT;
            end
            7'h06, 7'h07, 7'h0a, 7'h0b, 7'h0c, 7'h10, 7'h3e, 7'h3f,
            7'h41, 7'h42, 7'h43, 7'h45: begin
                cls = css_pkg::CLS_EXT;
            end
            default: begin
                cls = css_pkg::CLS_NONE;
            end
        endcase
    end

endmodule : css_func_class

// *** design/css_selector.sv ***
// command source selector: AHB-Lite registers, terminal mapping, source selection
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module css_selector #(
    parameter int NUM_FUNC = css_pkg::NUM_FUNC,
    parameter int NUM_TERM = css_pkg::NUM_TERM
) (
    input  wire logic                clk,
    input  wire logic                rst_n,

    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,

    // drive side
    input  wire logic                drive_running,
    input  wire logic [NUM_TERM-1:0] term_in,
    input  wire logic                comp_term_in,
    input  wire logic [NUM_FUNC-1:0] net_a_cmd,
    input  wire logic [NUM_FUNC-1:0] net_b_cmd,
    input  wire logic                net_reset_req,
    output logic [NUM_FUNC-1:0]      func_out,
    output logic                     comp_term_eff,
    output logic                     drive_reset_out,
    output logic                     op_net_out,
    output logic                     spd_net_out
);

    // software settings
    // reset: not in network mode
    logic                         op_cmd_source_param_r;
    logic [1:0]                   speed_cmd_source_param_r;
    logic [1:0]                   multispeed_comp_param_r;
    logic                         comm_source_param_a_r;
    logic                         comm_source_param_b_r;
    logic                         net_mode_r;
    logic [6:0]                   terminal_function_params_r [NUM_TERM];

    // bus data phase
    // address held for the data phase
    logic                         wr_pend_r;
    logic [7:0]                   wr_addr_r;
    logic                         addr_ok;

    // switching input tracking
    css_pkg::css_sw_type          sw_state_r;
    logic                         sw_applied_r;
    logic                         sw_assigned;
    logic                         cmd_source_switch_in;
    logic                         sw_ok;

    // resolved sources and per-function values
    // one class per function code
    css_pkg::css_sel_type         sel;
    css_pkg::css_cls_type         cls [NUM_FUNC];
    logic [NUM_FUNC-1:0]          spd_grp;
    logic [NUM_FUNC-1:0]          term_func;
    logic [NUM_FUNC-1:0]          func_nxt;
    logic [31:0]                  rd_val;

    // register index of a terminal function setting, or all ones if not one
    // below the table the subtraction wraps,
    // so the raw address is checked too
    function automatic logic [3:0] term_idx(input logic [7:0] a);
        logic [7:0] off;

        off = a - css_pkg::A_TERM;

        if (a >= css_pkg::A_TERM && off[1:0] == 2'h0 && off[7:2] < 6'(NUM_TERM))
            term_idx = off[5:2];
        else
            term_idx = 4'hf;
    endfunction : term_idx

    // the slave never inserts wait states and never errors
    // hsize is ignored: whole words only
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel & htrans[1] & hready;

    // capture write address phase; data comes in the next cycle
    // write timing:
    //   edge 1: address taken
    //   edge 2: data lands
    //   edge 3: outputs follow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            if (addr_ok)
                wr_addr_r <= haddr[7:0];
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_val = 32'h0000_0000;

        unique case (haddr[7:0])
            css_pkg::A_OPSRC:  rd_val[0]   = op_cmd_source_param_r;
            css_pkg::A_SPDSRC: rd_val[1:0] = speed_cmd_source_param_r;
            css_pkg::A_COMP:   rd_val[1:0] = multispeed_comp_param_r;
            css_pkg::A_COMMA:  rd_val[0]   = comm_source_param_a_r;
            css_pkg::A_COMMB:  rd_val[0]   = comm_source_param_b_r;
            css_pkg::A_MODE:   rd_val[0]   = net_mode_r;

            css_pkg::A_STATUS: begin
                rd_val[css_pkg::ST_ASSIGNED] = sw_assigned;
                rd_val[css_pkg::ST_APPLIED]  = sw_applied_r;
                rd_val[css_pkg::ST_PENDING]  = sw_state_r == css_pkg::SW_PENDING;
                rd_val[css_pkg::ST_OPNET]    = sel.op_net;
                rd_val[css_pkg::ST_SPDNET]   = sel.spd_net;
                rd_val[css_pkg::ST_SWOK]     = sw_ok;
            end

            default: begin
                if (term_idx(haddr[7:0]) != 4'hf)
                    rd_val[6:0] = terminal_function_params_r[term_idx(haddr[7:0])];
            end
        endcase
    end

    // read data is registered at the address phase so it stands in the data phase
    // read timing:
    //   edge 1: hrdata loaded
    //   data phase: it stands
    //   edge 2: master takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            hrdata <= rd_val;
    end

    // scalar settings written in the data phase
    // unmapped writes are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_cmd_source_param_r    <= css_pkg::OPSRC_RST;
            speed_cmd_source_param_r <= css_pkg::SPDSRC_RST;
            multispeed_comp_param_r  <= css_pkg::COMP_RST;
            comm_source_param_a_r    <= css_pkg::COMM_RST;
            comm_source_param_b_r    <= css_pkg::COMM_RST;
            net_mode_r               <= css_pkg::MODE_RST;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                css_pkg::A_OPSRC:  op_cmd_source_param_r    <= hwdata[0];
                css_pkg::A_SPDSRC: speed_cmd_source_param_r <= hwdata[1:0];
                css_pkg::A_COMP:   multispeed_comp_param_r  <= hwdata[1:0];
                css_pkg::A_COMMA:  comm_source_param_a_r    <= hwdata[0];
                css_pkg::A_COMMB:  comm_source_param_b_r    <= hwdata[0];
                css_pkg::A_MODE:   net_mode_r               <= hwdata[0];
                default: ;
            endcase
        end
    end

    // terminal function assignment table
    // unassigned terminals read 7f
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < NUM_TERM; t++)
                terminal_function_params_r[t] <= css_pkg::TERM_RST;
        end else if (wr_pend_r && term_idx(wr_addr_r) != 4'hf) begin
            terminal_function_params_r[term_idx(wr_addr_r)] <= hwdata[6:0];
        end
    end

    // gather each terminal onto the function it is assigned to
    // shared codes are ORed;
    // codes past the table drop
    always_comb begin
        term_func   = '0;
        sw_assigned = 1'b0;

        for (int t = 0; t < NUM_TERM; t++) begin
            if (terminal_function_params_r[t] == css_pkg::FC_SWITCH)
                sw_assigned = 1'b1;

            if (32'(terminal_function_params_r[t]) < NUM_FUNC)
                term_func[terminal_function_params_r[t]] =
                    term_func[terminal_function_params_r[t]] | term_in[t];
        end
    end

    // the switching input as seen on its assigned terminal
    // low while unassigned
    assign cmd_source_switch_in = term_func[css_pkg::FC_SWITCH];

    // a switch change during running waits for the stop
    // switch flow:
    //   stopped: apply next edge
    //   running: hold as pending
    //   stop: apply current value
    //   revert: drop the pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_state_r   <= css_pkg::SW_STABLE;
            sw_applied_r <= 1'b0;
        end else begin
            unique case (sw_state_r)
                css_pkg::SW_STABLE: begin
                    if (cmd_source_switch_in != sw_applied_r) begin
                        if (!drive_running)
                            sw_applied_r <= cmd_source_switch_in;
                        else
                            sw_state_r <= css_pkg::SW_PENDING;
                    end
                end

                css_pkg::SW_PENDING: begin
                    if (!drive_running) begin
                        sw_applied_r <= cmd_source_switch_in;
                        sw_state_r   <= css_pkg::SW_STABLE;
                    end else if (cmd_source_switch_in == sw_applied_r) begin
                        sw_state_r <= css_pkg::SW_STABLE;
                    end
                end
            endcase
        end
    end

    // an unassigned switch behaves as if it were on
    assign sw_ok = !sw_assigned || sw_applied_r;

    // resolve sources; combinational so any setting change takes effect at once
    // op goes to network when:
    //   network mode is set,
    //   the switch allows it,
    //   and the setting is 0
    always_comb begin
        sel.op_net   = net_mode_r && sw_ok &&
                       op_cmd_source_param_r == css_pkg::OPSRC_NET;
        sel.spd_net  = net_mode_r && sw_ok &&
                       speed_cmd_source_param_r == css_pkg::SPDSRC_NET;

        sel.op_port  = comm_source_param_a_r;
        sel.spd_port = comm_source_param_b_r;
    end

    // one class decoder per input function
    // class meaning:
    //   ext: terminal only
    //   net: network only
    //   comb: either side
    //   none: ignored
    for (genvar f = 0; f < NUM_FUNC; f++) begin : g_cls
        css_func_class u_cls (
            .code    (7'(f)),
            .sel     (sel),
            .cls     (cls[f]),
            .spd_grp (spd_grp[f])
        );
    end

    // pick the value of each function from its class
    // port select per group:
    //   0: port a, 1: port b
    always_comb begin
        logic net_bit;
        net_bit  = 1'b0;
        func_nxt = '0;

        for (int f = 0; f < NUM_FUNC; f++) begin
            // speed functions use the speed-side port, others the operation-side one
            net_bit = (spd_grp[f] ? sel.spd_port : sel.op_port) ?
                      net_b_cmd[f] : net_a_cmd[f];

            unique case (cls[f])
                css_pkg::CLS_EXT:  func_nxt[f] = term_func[f];
                css_pkg::CLS_NET:  func_nxt[f] = net_bit;
                css_pkg::CLS_COMB: func_nxt[f] = term_func[f] | net_bit;
                css_pkg::CLS_NONE: func_nxt[f] = 1'b0;
                default:           func_nxt[f] = 1'b0;
            endcase
        end
    end

    // registered function outputs, refreshed every cycle
    // one stage keeps glitches off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            func_out <= '0;
        else
            func_out <= func_nxt;
    end

    // compensation terminal counts only with compensation enabled
    // any other setting blocks it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            comp_term_eff <= 1'b0;
        else
            comp_term_eff <= comp_term_in &&
                             multispeed_comp_param_r == css_pkg::COMP_ON;
    end

    // network reset passes only while the switch permits network control
    // a terminal reset always passes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            drive_reset_out <= 1'b0;
        else
            drive_reset_out <= (net_reset_req && sw_ok) ||
                               term_func[css_pkg::FC_RESET];
    end

    // resolved sources for the rest of the controller
    // status bits lead by one edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_net_out  <= 1'b0;
            spd_net_out <= 1'b0;
        end else begin
            op_net_out  <= sel.op_net;
            spd_net_out <= sel.spd_net;
        end
    end

endmodule : css_selector

// *** test/css_selector_sva.sv ***
// assertion checker for the command source selector ports
`timescale 1ns/100ps
module css_selector_chk #(
    parameter int NUM_FUNC = 75,
    parameter int NUM_TERM = 12
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    input wire logic                drive_running,
    input wire logic [NUM_TERM-1:0] term_in,
    input wire logic                comp_term_in,
    input wire logic                net_reset_req,
    input wire logic                comp_term_eff,
    input wire logic                drive_reset_out,
    input wire logic                op_net_out,
    input wire logic                spd_net_out
);
    logic       wr_ph_r;
    logic [7:0] wa_r;
    logic       op_r;
    logic       mode_r;
    logic [1:0] spd_r;
    logic [1:0] comp_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // remember a write address phase so the data phase can be decoded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ph_r <= 1'b0;
            wa_r    <= 8'h00;
        end else if (hready) begin
            wr_ph_r <= hsel & htrans[1] & hwrite;
            wa_r    <= haddr[7:0];
        end
    end

    // shadow of the source settings, updated on the same edge as the design
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_r   <= css_pkg::OPSRC_RST;
            mode_r <= css_pkg::MODE_RST;
            spd_r  <= css_pkg::SPDSRC_RST;
            comp_r <= css_pkg::COMP_RST;
        end else if (wr_ph_r && hready) begin
            case (wa_r)
                css_pkg::A_OPSRC:  op_r   <= hwdata[0];
                css_pkg::A_MODE:   mode_r <= hwdata[0];
                css_pkg::A_SPDSRC: spd_r  <= hwdata[1:0];
                css_pkg::A_COMP:   comp_r <= hwdata[1:0];
                default:           ;
            endcase
        end
    end

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    rd_hold_a: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
        else $error("read data moved without a read");
    comp_gate_a: assert property (
        comp_term_eff == ($past(comp_term_in) && ($past(comp_r) == css_pkg::COMP_ON)))
        else $error("compensation input gating wrong");
    op_mode_a: assert property (
        op_net_out |-> $past(mode_r) && ($past(op_r) == css_pkg::OPSRC_NET))
        else $error("operation source network outside its settings");
    spd_mode_a: assert property (
        spd_net_out |-> $past(mode_r) && ($past(spd_r) == css_pkg::SPDSRC_NET))
        else $error("speed source network outside its settings");
    net_reset_a: assert property (
        drive_reset_out |-> $past(net_reset_req) || ($past(term_in) != '0))
        else $error("drive reset without any request");
    op_hold_a: assert property ($changed(op_net_out) |-> $past(wr_ph_r) ||
        $past(wr_ph_r, 2) || !$past(drive_running) || !$past(drive_running, 2))
        else $error("operation source moved while running");
    spd_hold_a: assert property ($changed(spd_net_out) |-> $past(wr_ph_r) ||
        $past(wr_ph_r, 2) || !$past(drive_running) || !$past(drive_running, 2))
        else $error("speed source moved while running");
endmodule : css_selector_chk

bind css_selector css_selector_chk #(.NUM_FUNC(NUM_FUNC), .NUM_TERM(NUM_TERM)) u_chk (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .drive_running(drive_running), .term_in(term_in), .comp_term_in(comp_term_in),
    .net_reset_req(net_reset_req), .comp_term_eff(comp_term_eff),
    .drive_reset_out(drive_reset_out), .op_net_out(op_net_out), .spd_net_out(spd_net_out));

// *** test/css_far_model.sv ***
// network master and terminal source model facing the selector
`timescale 1ns/100ps
module css_far_model #(
    parameter int NUM_FUNC = 75,
    parameter int NUM_TERM = 12
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [NUM_FUNC-1:0] a_req,
    input wire logic [NUM_FUNC-1:0] b_req,
    input wire logic [NUM_TERM-1:0] term_req,
    input wire logic                run_req,
    input wire logic                rst_req,
    input wire logic                comp_req,
    output logic [NUM_FUNC-1:0]     net_a_cmd,
    output logic [NUM_FUNC-1:0]     net_b_cmd,
    output logic [NUM_TERM-1:0]     term_in,
    output logic                    drive_running,
    output logic                    net_reset_req,
    output logic                    comp_term_in
);
    // requests land one edge after they are asked for
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            net_a_cmd     <= '0;
            net_b_cmd     <= '0;
            term_in       <= '0;
            drive_running <= 1'b0;
            net_reset_req <= 1'b0;
            comp_term_in  <= 1'b0;
        end else begin
            net_a_cmd     <= a_req;
            net_b_cmd     <= b_req;
            term_in       <= term_req;
            drive_running <= run_req;
            net_reset_req <= rst_req;
            comp_term_in  <= comp_req;
        end
    end
endmodule : css_far_model

// *** test/css_selector_test.sv ***
// self-checking bench for the command source selector
`timescale 1ns/100ps
module css_selector_test;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [74:0] a_req, b_req, net_a_cmd, net_b_cmd, func_out;
    logic [11:0] term_req, term_in;
    logic        run_req, rst_req, comp_req, drive_running, net_reset_req, comp_term_in;
    logic        comp_term_eff, drive_reset_out, op_net_out, spd_net_out;
    int          bad_count, samples_checked, cycles;
    logic [6:0]  codes [6] = '{7'h3c, 7'h01, 7'h44, 7'h04, 7'h1c, 7'h3e};

    css_selector uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .drive_running(drive_running),
        .term_in(term_in), .comp_term_in(comp_term_in), .net_a_cmd(net_a_cmd),
        .net_b_cmd(net_b_cmd), .net_reset_req(net_reset_req), .func_out(func_out),
        .comp_term_eff(comp_term_eff), .drive_reset_out(drive_reset_out),
        .op_net_out(op_net_out), .spd_net_out(spd_net_out));

    css_far_model far (.clk(clk), .rst_n(rst_n), .a_req(a_req), .b_req(b_req),
        .term_req(term_req), .run_req(run_req), .rst_req(rst_req), .comp_req(comp_req),
        .net_a_cmd(net_a_cmd), .net_b_cmd(net_b_cmd), .term_in(term_in),
        .drive_running(drive_running), .net_reset_req(net_reset_req),
        .comp_term_in(comp_term_in));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one single transfer; entered at a clock edge, leaves at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd_chk

    // inputs need a few edges to reach the outputs
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle

    initial begin
        {hsel, hwrite, run_req, rst_req, comp_req} = 5'h00;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {a_req, b_req, term_req} = '0;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset values, an unmapped place, and the terminal map
        for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
        rd_chk(css_pkg::A_STATUS, 32'h20);
        rd_chk(css_pkg::A_TERM + 8'h2c, 32'h7f);
        wr(8'h30, 32'h1);
        rd_chk(8'h30, 32'h0);
        for (int t = 0; t < 6; t++) wr(css_pkg::A_TERM + 8'(4 * t), {25'h0, codes[t]});
        rd_chk(css_pkg::A_TERM + 8'h08, 32'h44);
        // not network mode: terminals rule, combined takes either side
        for (int p = 0; p < 2; p++) begin
            a_req <= p ? '0 : '1;
            term_req <= p ? 12'h03f : 12'h000;
            settle();
            chk(32'(op_net_out), 32'h0);
            chk(32'(func_out[60]), 32'(p));
            chk(32'(func_out[1]), 32'(p));
            chk(32'(func_out[68]), 32'(p));
            chk(32'(func_out[4]), 32'h1);
        end
        // network mode, switch unassigned: sources from the settings
        wr(css_pkg::A_MODE, 32'h1);
        a_req <= '1;
        term_req <= 12'h004;
        settle();
        chk({30'h0, op_net_out, spd_net_out}, 32'h3);
        chk({29'h0, func_out[60], func_out[28], func_out[1]}, 32'h7);
        chk(32'(func_out[68]), 32'h1);
        wr(css_pkg::A_COMMA, 32'h1);
        wr(css_pkg::A_COMMB, 32'h1);
        settle();
        chk({29'h0, func_out[60], func_out[28], func_out[1]}, 32'h0);
        for (int s = 2; s >= 0; s--) begin
            wr(css_pkg::A_SPDSRC, 32'(s));
            settle();
            chk(32'(spd_net_out), 32'(s == 0));
        end
        wr(css_pkg::A_OPSRC, 32'h1);
        term_req <= 12'h011;
        settle();
        chk({30'h0, op_net_out, func_out[28]}, 32'h1);
        wr(css_pkg::A_OPSRC, 32'h0);
        wr(css_pkg::A_COMMA, 32'h0);
        // switching input assigned on terminal 6, changed while running
        term_req <= 12'h040;
        wr(css_pkg::A_TERM + 8'h18, 32'h43);
        settle();
        rd_chk(css_pkg::A_STATUS, 32'h3b);
        run_req <= 1'b1;
        rst_req <= 1'b1;
        settle();
        term_req <= 12'h000;
        settle();
        chk({30'h0, op_net_out, drive_reset_out}, 32'h3);
        rd_chk(css_pkg::A_STATUS, 32'h3f);
        run_req <= 1'b0;
        settle();
        chk({29'h0, op_net_out, spd_net_out, func_out[60]}, 32'h0);
        chk(32'(drive_reset_out), 32'h0);
        rd_chk(css_pkg::A_STATUS, 32'h01);
        term_req <= 12'h020;
        settle();
        chk(32'(drive_reset_out), 32'h1);
        // compensation terminal counts only at setting 1
        comp_req <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(css_pkg::A_COMP, 32'(c));
            settle();
            chk(32'(comp_term_eff), 32'(c == 1));
        end
        // unassigning the reset terminal must drop its effect within one settle of six edges
        wr(css_pkg::A_TERM + 8'h14, 32'h7f);
        settle();
        chk(32'(drive_reset_out), 32'h0);
        give_verdict();
    end
endmodule : css_selector_test
